// ==== verilog/fprm_top.sv ====
// fprm_top: power-mode and reset controller for a parallel flash port.
// assumes async active-low pins from a host, sampled on a 100 MHz clock.
//
// Function
// - no ready until 60 us after power
// - auto power saving 5 us after idle
// - selected and out of reset means active
// - deselect in read gives standby, outputs off
// - deselect never stops program or erase
// - command write needs write strobe and select
// - contents change only after two-step sequence
// - reset pin low disables, ignores inputs
// - command state kept across select, supply, engine
// - command interface defaults to read array
// - reset mode disables circuits, outputs off
// - reset exit: status 80h, async page
// - reset aborts program or erase
`timescale 1ns/1ps
module fprm_top #(
  parameter int PWR_CYC = fprm_pkg::PWR_VALID_CYC,
  parameter int APS_CYC = fprm_pkg::APS_DELAY_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic RESET_PIN_N,
  input wire logic SELECT_N,
  input wire logic OUT_EN_N,
  input wire logic WRITE_N,
  input wire logic [7:0] DATA_IN,
  input wire logic ADDR_ACTIVITY,
  input wire logic SENSE_BUSY,
  input wire logic WSM_DONE,
  output logic [2:0] MODE,
  output logic READY,
  output logic DATA_OE_N,
  output logic WSM_START,
  output logic WSM_ABORT,
  output logic READ_ARRAY,
  output logic [7:0] STATUS,
  output logic CFG_SYNC
);
  typedef struct packed {
    logic [2:0] rst_s;
    logic [2:0] sel_s;
    logic [2:0] oe_s;
    logic [2:0] we_s;
    logic [2:0] adr_s;
    logic rst_q;
    logic sel_q;
    logic oe_q;
    logic we_q;
    logic adr_q;
    fprm_pkg::fprm_mode_type mode;
    logic [fprm_pkg::CNT_W-1:0] pwr_cnt;
    logic [fprm_pkg::CNT_W-1:0] aps_cnt;
    logic pwr_ok;
    logic ready;
    logic data_oe_n;
    logic stb;
    logic abort;
    logic start;
    logic rd_arr;
    logic [7:0] status;
  } fprm_state_type;

  fprm_state_type s_reg;
  fprm_state_type s_next;
  fprm_cmd_if cif ();

  localparam logic [fprm_pkg::CNT_W-1:0] PWR_LIM =
    fprm_pkg::CNT_W'(PWR_CYC);
  localparam logic [fprm_pkg::CNT_W-1:0] APS_LIM =
    fprm_pkg::CNT_W'(APS_CYC);

  // agreement of second and third stage counts as a change
  function automatic logic settle(input logic [2:0] sync, input logic old);
    settle = (sync[1] == sync[2]) ? sync[2] : old;
  endfunction : settle

  fprm_cmd u_cmd (
    .clk(CLK),
    .rst_n(RST_N),
    .cif(cif)
  );

  // write strobe and engine feedback toward command interface
  assign cif.write_stb = s_reg.stb;
  assign cif.write_data = DATA_IN;
  assign cif.enable = s_reg.rst_q;
  assign cif.wsm_done = WSM_DONE;

  // next state of synchronisers, mode and counters
  always_comb begin
    s_next = s_reg;
    s_next.rst_s = {s_reg.rst_s[1:0], RESET_PIN_N};
    s_next.sel_s = {s_reg.sel_s[1:0], SELECT_N};
    s_next.oe_s = {s_reg.oe_s[1:0], OUT_EN_N};
    s_next.we_s = {s_reg.we_s[1:0], WRITE_N};
    s_next.adr_s = {s_reg.adr_s[1:0], ADDR_ACTIVITY};
    s_next.rst_q = settle(s_reg.rst_s, s_reg.rst_q);
    s_next.sel_q = settle(s_reg.sel_s, s_reg.sel_q);
    s_next.oe_q = settle(s_reg.oe_s, s_reg.oe_q);
    s_next.we_q = settle(s_reg.we_s, s_reg.we_q);
    s_next.adr_q = settle(s_reg.adr_s, s_reg.adr_q);
    s_next.stb = 1'b0;
    s_next.abort = 1'b0;
    s_next.start = cif.start_op;
    s_next.rd_arr = cif.read_array;
    s_next.status = cif.status;
    // power-valid timer runs once from core reset release
    if (!s_reg.pwr_ok) begin
      if (s_reg.pwr_cnt >= PWR_LIM - 1'b1)
        s_next.pwr_ok = 1'b1;
      else
        s_next.pwr_cnt = s_reg.pwr_cnt + 1'b1;
    end
    if (!s_reg.rst_q) begin
      s_next.mode = fprm_pkg::FPRM_RESET;
      s_next.abort = cif.op_busy;
      s_next.aps_cnt = '0;
    end else begin
      // write taken on falling edge of qualified write strobe
      if (!s_reg.sel_q && !s_reg.we_q && s_reg.we_s[2] == 1'b0 &&
          s_reg.mode != fprm_pkg::FPRM_WAKE && !s_next.we_q &&
          s_reg.we_q != s_reg.stb) begin
        s_next.stb = 1'b0;
      end
      s_next.stb = !s_reg.sel_q && s_reg.we_q && !s_next.we_q &&
        s_reg.mode != fprm_pkg::FPRM_WAKE;
      case (s_reg.mode)
        fprm_pkg::FPRM_RESET: begin
          s_next.mode = fprm_pkg::FPRM_WAKE;
        end
        fprm_pkg::FPRM_WAKE: begin
          if (s_reg.pwr_ok)
            s_next.mode = fprm_pkg::FPRM_STANDBY;
        end
        fprm_pkg::FPRM_ACTIVE, fprm_pkg::FPRM_APS: begin
          if (s_reg.sel_q && !cif.op_busy) begin
            s_next.mode = fprm_pkg::FPRM_STANDBY;
          end else if (s_reg.sel_q) begin
            s_next.mode = fprm_pkg::FPRM_ACTIVE;
          end else if (SENSE_BUSY || s_reg.adr_q || !s_reg.we_q) begin
            s_next.mode = fprm_pkg::FPRM_ACTIVE;
            s_next.aps_cnt = '0;
          end else if (s_reg.aps_cnt >= APS_LIM - 1'b1) begin
            s_next.mode = fprm_pkg::FPRM_APS;
          end else begin
            s_next.aps_cnt = s_reg.aps_cnt + 1'b1;
          end
        end
        fprm_pkg::FPRM_STANDBY: begin
          if (!s_reg.sel_q) begin
            s_next.mode = fprm_pkg::FPRM_ACTIVE;
            s_next.aps_cnt = '0;
          end
        end
        default: s_next.mode = fprm_pkg::FPRM_RESET;
      endcase
    end
    s_next.ready = s_next.pwr_ok && s_next.rst_q &&
      s_next.mode != fprm_pkg::FPRM_WAKE &&
      s_next.mode != fprm_pkg::FPRM_RESET;
    // data drivers only when selected, read enabled, not in reset
    s_next.data_oe_n = !(s_next.rst_q && !s_next.sel_q && !s_next.oe_q &&
      s_next.we_q && (s_next.mode == fprm_pkg::FPRM_ACTIVE ||
      s_next.mode == fprm_pkg::FPRM_APS));
  end

  // single state register, reset pin assumed low and other pins inactive at reset
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_reg <= '{rst_s: 3'h0, sel_s: 3'h7, oe_s: 3'h7, we_s: 3'h7,
        adr_s: 3'h0, rst_q: 1'b0, sel_q: 1'b1, oe_q: 1'b1, we_q: 1'b1,
        adr_q: 1'b0, mode: fprm_pkg::FPRM_RESET, pwr_cnt: '0,
        aps_cnt: '0, pwr_ok: 1'b0, ready: 1'b0, data_oe_n: 1'b1,
        stb: 1'b0, abort: 1'b0, start: 1'b0, rd_arr: 1'b1,
        status: fprm_pkg::STATUS_RESET};
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register, CFG_SYNC a constant
  assign MODE = s_reg.mode;
  assign READY = s_reg.ready;
  assign DATA_OE_N = s_reg.data_oe_n;
  assign WSM_START = s_reg.start;
  assign WSM_ABORT = s_reg.abort;
  assign READ_ARRAY = s_reg.rd_arr;
  assign STATUS = s_reg.status;
  assign CFG_SYNC = fprm_pkg::CFG_ASYNC_PAGE;
endmodule : fprm_top

// ==== inc/fprm_pkg.sv ====
// fprm_pkg: constants and types for the flash power and reset mode block.
// assumes a 100 MHz core clock; no import, every use is fprm_pkg::name.
package fprm_pkg;
  localparam int CLK_MHZ = 100;
  localparam int PWR_VALID_US = 60;
  localparam int APS_DELAY_US = 5;
  localparam int PWR_VALID_CYC = PWR_VALID_US * CLK_MHZ;
  localparam int APS_DELAY_CYC = APS_DELAY_US * CLK_MHZ;
  localparam int CNT_W = 16;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic CFG_ASYNC_PAGE = 1'b0;

  typedef enum logic [2:0] {
    FPRM_RESET = 3'b000,
    FPRM_WAKE = 3'b001,
    FPRM_ACTIVE = 3'b011,
    FPRM_APS = 3'b010,
    FPRM_STANDBY = 3'b110
  } fprm_mode_type;

  typedef enum logic [1:0] {
    FPRM_CI_READ = 2'b00,
    FPRM_CI_SETUP_PGM = 2'b01,
    FPRM_CI_SETUP_ERS = 2'b11,
    FPRM_CI_STATUS = 2'b10
  } fprm_ci_type;
endpackage : fprm_pkg

// ==== inc/fprm_cmd_if.sv ====
// fprm_cmd_if: strobe and command-interface signals between the mode
// controller and the command interface; assumes one clock domain.
`timescale 1ns/1ps
interface fprm_cmd_if;
  logic write_stb;
  logic [7:0] write_data;
  logic enable;
  logic wsm_done;
  logic start_op;
  logic op_busy;
  logic read_array;
  logic [7:0] status;
  modport ctl (output write_stb, output write_data, output enable,
    output wsm_done, input start_op, input op_busy, input read_array,
    input status);
  modport ci (input write_stb, input write_data, input enable,
    input wsm_done, output start_op, output op_busy, output read_array,
    output status);
endinterface : fprm_cmd_if

// ==== verilog/fprm_cmd.sv ====
// fprm_cmd: command interface latch with two-step program/erase sequence.
// assumes strobes already qualified and synchronised by the controller.
`timescale 1ns/1ps
module fprm_cmd (
  input wire logic clk,
  input wire logic rst_n,
  fprm_cmd_if.ci cif
);
  typedef struct packed {
    fprm_pkg::fprm_ci_type ci;
    logic busy;
    logic start;
    logic [7:0] status;
  } fprm_ci_state_type;

  fprm_ci_state_type s_reg;
  fprm_ci_state_type s_next;

  // decode next command state; written strobes, engine done and enable low change it
  always_comb begin
    s_next = s_reg;
    s_next.start = 1'b0;
    if (!cif.enable) begin
      s_next.ci = fprm_pkg::FPRM_CI_READ;
      s_next.busy = 1'b0;
      s_next.status = fprm_pkg::STATUS_RESET;
    end else begin
      if (cif.wsm_done && s_reg.busy) begin
        s_next.busy = 1'b0;
        s_next.status = fprm_pkg::STATUS_RESET; // stays in status
      end
      if (cif.write_stb) begin
        case (s_reg.ci)
          fprm_pkg::FPRM_CI_SETUP_PGM, fprm_pkg::FPRM_CI_SETUP_ERS: begin
            // second step must confirm or the sequence is dropped
            if (cif.write_data == fprm_pkg::CMD_CONFIRM && !s_reg.busy) begin
              s_next.start = 1'b1;
              s_next.busy = 1'b1;
              s_next.status = 8'h00;
            end
            s_next.ci = fprm_pkg::FPRM_CI_STATUS;
          end
          default: begin
            if (cif.write_data == fprm_pkg::CMD_PROGRAM)
              s_next.ci = fprm_pkg::FPRM_CI_SETUP_PGM;
            else if (cif.write_data == fprm_pkg::CMD_ERASE)
              s_next.ci = fprm_pkg::FPRM_CI_SETUP_ERS;
            else if (cif.write_data == fprm_pkg::CMD_READ_ARRAY)
              s_next.ci = fprm_pkg::FPRM_CI_READ;
            else
              s_next.ci = s_reg.ci;
          end
        endcase
      end
    end
  end

  // state register; held otherwise across select and supply changes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{ci: fprm_pkg::FPRM_CI_READ, busy: 1'b0, start: 1'b0,
        status: fprm_pkg::STATUS_RESET};
    end else begin
      s_reg <= s_next;
    end
  end

  assign cif.start_op = s_reg.start;
  assign cif.op_busy = s_reg.busy;
  assign cif.read_array = (s_reg.ci == fprm_pkg::FPRM_CI_READ);
  assign cif.status = s_reg.status;
endmodule : fprm_cmd

// ==== dv/fprm_host.sv ====
// fprm_host: host model driving the flash control pins from tasks.
// assumes the bench calls its tasks; pins move 1 ns after CLK.
`timescale 1ns/1ps
module fprm_host (
  input wire logic CLK,
  output logic RESET_PIN_N,
  output logic SELECT_N,
  output logic OUT_EN_N,
  output logic WRITE_N,
  output logic [7:0] DATA_IN,
  output logic ADDR_ACTIVITY
);
  // device held in reset while supplies settle
  initial begin
    RESET_PIN_N = 1'h0;
    SELECT_N = 1'h1;
    OUT_EN_N = 1'h1;
    WRITE_N = 1'h1;
    DATA_IN = 8'h00;
    ADDR_ACTIVITY = 1'h0;
  end
  // one command byte, data inverted 4 cycles after the strobe
  task write_cmd(input logic [7:0] b);
    @(posedge CLK) #1;
    DATA_IN = b;
    WRITE_N = 1'h0;
    repeat (6) @(posedge CLK);
    #1 WRITE_N = 1'h1;
    repeat (4) @(posedge CLK);
    #1 DATA_IN = ~b;
  endtask : write_cmd
  // reset, select, output enable and address activity levels
  task pins(input logic r, input logic s, input logic o, input logic a);
    @(posedge CLK) #1;
    RESET_PIN_N = r;
    SELECT_N = s;
    OUT_EN_N = o;
    ADDR_ACTIVITY = a;
  endtask : pins
endmodule : fprm_host

// ==== dv/fprm_top_chk.sv ====
// fprm_top_chk: mode, ready and status relations at the top ports.
// assumes a bind from the bench; one clock, async active-low reset.
`timescale 1ns/1ps
module fprm_top_chk #(
  parameter int PWR_CYC = 20,
  parameter int APS_CYC = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic RESET_PIN_N,
  input wire logic SELECT_N,
  input wire logic WRITE_N,
  input wire logic ADDR_ACTIVITY,
  input wire logic SENSE_BUSY,
  input wire logic [2:0] MODE,
  input wire logic READY,
  input wire logic DATA_OE_N,
  input wire logic READ_ARRAY,
  input wire logic [7:0] STATUS,
  input wire logic CFG_SYNC
);
  logic [15:0] pwr_cnt;
  logic [15:0] idle_cnt;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // cycles since core reset, cycles idle while selected
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pwr_cnt <= 16'h0000;
      idle_cnt <= 16'h0000;
    end else begin
      if (pwr_cnt != 16'hFFFF)
        pwr_cnt <= pwr_cnt + 16'h0001;
      if (SELECT_N || !RESET_PIN_N || ADDR_ACTIVITY || SENSE_BUSY ||
          !WRITE_N || !READY || STATUS != 8'h80)
        idle_cnt <= 16'h0000;
      else if (idle_cnt != 16'hFFFF)
        idle_cnt <= idle_cnt + 16'h0001;
    end
  end
  property p_rst_mode;
    !RESET_PIN_N [*6] |-> MODE == 3'h0;
  endproperty
  a_rst_mode: assert property (p_rst_mode)
    else $error("reset pin low but mode not reset");
  property p_rst_oe;
    MODE == 3'h0 |-> DATA_OE_N;
  endproperty
  a_rst_oe: assert property (p_rst_oe)
    else $error("outputs on in reset mode");
  property p_ready;
    READY |-> pwr_cnt >= PWR_CYC - 1;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready before power timer");
  property p_stby_oe;
    MODE == 3'h6 |-> DATA_OE_N;
  endproperty
  a_stby_oe: assert property (p_stby_oe)
    else $error("outputs on in standby");
  property p_wake;
    MODE == 3'h1 |-> STATUS == 8'h80 && READ_ARRAY && !CFG_SYNC;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wrong defaults after reset");
  property p_active;
    (!SELECT_N && RESET_PIN_N && READY) [*6] |-> MODE inside {3'h3, 3'h2};
  endproperty
  a_active: assert property (p_active)
    else $error("selected but not active");
  property p_aps;
    idle_cnt == APS_CYC + 6 |-> MODE == 3'h2;
  endproperty
  a_aps: assert property (p_aps)
    else $error("no power saving when idle");
  property p_stby_done;
    MODE == 3'h6 |-> STATUS == 8'h80;
  endproperty
  a_stby_done: assert property (p_stby_done)
    else $error("standby during operation");
endmodule : fprm_top_chk

// ==== dv/tb_flash_power_reset_modes.sv ====
// tb_flash_power_reset_modes: scenario bench for the mode controller.
// assumes fprm_host drives pins; bench drives sensing and engine done.
`timescale 1ns/1ps
module tb_flash_power_reset_modes;
  localparam int PWR = 20;
  localparam int AUTO_POWER_SAVING = 8;
  logic CLK, RST_N, SENSE_BUSY, WSM_DONE, READY, DATA_OE_N;
  logic RESET_PIN_N, SELECT_N, OUT_EN_N, WRITE_N, ADDR_ACTIVITY;
  logic WSM_START, WSM_ABORT, READ_ARRAY, CFG_SYNC;
  logic [7:0] DATA_IN, STATUS;
  logic [2:0] MODE;
  int error_cnt = 0;
  int n_tests = 0;
  int n_start = 0;
  int n_abort = 0;
  fprm_top #(.PWR_CYC(PWR), .APS_CYC(AUTO_POWER_SAVING)) i_fprm_top (.CLK(CLK),
    .RST_N(RST_N), .RESET_PIN_N(RESET_PIN_N), .SELECT_N(SELECT_N),
    .OUT_EN_N(OUT_EN_N), .WRITE_N(WRITE_N), .DATA_IN(DATA_IN),
    .ADDR_ACTIVITY(ADDR_ACTIVITY), .SENSE_BUSY(SENSE_BUSY),
    .WSM_DONE(WSM_DONE), .MODE(MODE), .READY(READY),
    .DATA_OE_N(DATA_OE_N), .WSM_START(WSM_START), .WSM_ABORT(WSM_ABORT),
    .READ_ARRAY(READ_ARRAY), .STATUS(STATUS), .CFG_SYNC(CFG_SYNC));
  fprm_host i_fprm_host (.CLK(CLK), .RESET_PIN_N(RESET_PIN_N),
    .SELECT_N(SELECT_N), .OUT_EN_N(OUT_EN_N), .WRITE_N(WRITE_N),
    .DATA_IN(DATA_IN), .ADDR_ACTIVITY(ADDR_ACTIVITY));
  // count start and abort pulses
  always @(posedge CLK) begin
    n_start += (WSM_START === 1'h1);
    n_abort += (WSM_ABORT === 1'h1);
  end
  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task give_verdict;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // bounded wait for ready
  task wait_ready;
    int i;
    for (i = 0; i < 200 && READY !== 1'h1; i++)
      #10;
    if (READY !== 1'h1) begin
      error_cnt++;
      give_verdict;
    end
  endtask : wait_ready
  task t_power;
    chk("ready_early", {7'h00, READY}, 8'h00);
    i_fprm_host.pins(1'h1, 1'h1, 1'h0, 1'h0);
    wait_ready;
    #40;
    chk("status", STATUS, 8'h80);
    chk("read_array", {7'h00, READ_ARRAY}, 8'h01);
    chk("cfg", {7'h00, CFG_SYNC}, 8'h00);
    chk("stby", {5'h00, MODE}, 8'h06);
    chk("oe", {7'h00, DATA_OE_N}, 8'h01);
  endtask : t_power
  task t_aps;
    i_fprm_host.pins(1'h1, 1'h0, 1'h0, 1'h1);
    #60;
    chk("active", {5'h00, MODE}, 8'h03);
    i_fprm_host.pins(1'h1, 1'h0, 1'h0, 1'h0);
    #((AUTO_POWER_SAVING + 8) * 10);
    chk("aps", {5'h00, MODE}, 8'h02);
  endtask : t_aps
  // sensing wakes from power saving; output enable gates the drivers
  task t_sense;
    @(posedge CLK) #1 SENSE_BUSY = 1'h1;
    #20;
    chk("sense_act", {5'h00, MODE}, 8'h03);
    chk("oe_on", {7'h00, DATA_OE_N}, 8'h00);
    SENSE_BUSY = 1'h0;
    i_fprm_host.pins(1'h1, 1'h0, 1'h1, 1'h0);
    #60;
    chk("oe_gated", {7'h00, DATA_OE_N}, 8'h01);
    i_fprm_host.pins(1'h1, 1'h0, 1'h0, 1'h0);
    #((AUTO_POWER_SAVING + 8) * 10);
    chk("aps2", {5'h00, MODE}, 8'h02);
  endtask : t_sense
  task t_prog;
    i_fprm_host.pins(1'h1, 1'h1, 1'h0, 1'h0);
    i_fprm_host.write_cmd(8'h40);
    i_fprm_host.write_cmd(8'hD0);
    chk("blocked", n_start[7:0], 8'h00);
    i_fprm_host.pins(1'h1, 1'h0, 1'h0, 1'h0);
    i_fprm_host.write_cmd(8'h40);
    chk("setup_only", n_start[7:0], 8'h00);
    i_fprm_host.write_cmd(8'hD0);
    chk("start", n_start[7:0], 8'h01);
    chk("busy", STATUS, 8'h00);
    i_fprm_host.pins(1'h1, 1'h1, 1'h0, 1'h0);
    #80;
    chk("busy_stby", {7'h00, MODE == 3'h6}, 8'h00);
    chk("ra_kept", {7'h00, READ_ARRAY}, 8'h00);
    @(posedge CLK) #1 WSM_DONE = 1'h1;
    @(posedge CLK) #1 WSM_DONE = 1'h0;
    #80;
    chk("stby_done", {5'h00, MODE}, 8'h06);
    chk("oe_off", {7'h00, DATA_OE_N}, 8'h01);
    chk("ra_after", {7'h00, READ_ARRAY}, 8'h00);
    i_fprm_host.pins(1'h1, 1'h0, 1'h0, 1'h0);
    i_fprm_host.write_cmd(8'hFF);
    chk("ra_back", {7'h00, READ_ARRAY}, 8'h01);
  endtask : t_prog
  task t_reset;
    i_fprm_host.write_cmd(8'h20);
    i_fprm_host.write_cmd(8'hD0);
    chk("erase", n_start[7:0], 8'h02);
    i_fprm_host.pins(1'h0, 1'h0, 1'h0, 1'h0);
    i_fprm_host.write_cmd(8'h40);
    chk("abort", {7'h00, n_abort > 0}, 8'h01);
    chk("rst", {5'h00, MODE}, 8'h00);
    chk("rst_oe", {7'h00, DATA_OE_N}, 8'h01);
    i_fprm_host.pins(1'h1, 1'h0, 1'h0, 1'h0);
    #80;
    wait_ready;
    chk("status2", STATUS, 8'h80);
    chk("ra2", {7'h00, READ_ARRAY}, 8'h01);
    i_fprm_host.write_cmd(8'hD0);
    chk("no_start", n_start[7:0], 8'h02);
  endtask : t_reset
  // free-running clock
  initial begin
    CLK = 1'h0;
    forever #5 CLK = ~CLK;
  end
  // reset, scenarios, verdict
  initial begin
    RST_N = 1'h0;
    SENSE_BUSY = 1'h0;
    WSM_DONE = 1'h0;
    repeat (2) @(posedge CLK);
    #1 RST_N = 1'h1;
    t_power;
    t_aps;
    t_sense;
    t_prog;
    t_reset;
    give_verdict;
  end
endmodule : tb_flash_power_reset_modes
bind fprm_top fprm_top_chk #(.PWR_CYC(PWR_CYC), .APS_CYC(APS_CYC))
  i_fprm_top_chk (.CLK(CLK), .RST_N(RST_N), .RESET_PIN_N(RESET_PIN_N),
  .SELECT_N(SELECT_N), .WRITE_N(WRITE_N), .ADDR_ACTIVITY(ADDR_ACTIVITY),
  .SENSE_BUSY(SENSE_BUSY), .MODE(MODE), .READY(READY),
  .DATA_OE_N(DATA_OE_N), .READ_ARRAY(READ_ARRAY), .STATUS(STATUS),
  .CFG_SYNC(CFG_SYNC));
